//--- fsg_pkg.sv
package fsg_pkg;

  // Flash geometry
  localparam int unsigned FLASH_ADDR_W = 12;
  localparam int unsigned CPU_ADDR_W   = 16;
  localparam int unsigned DATA_W       = 8;

  // Area boundaries inside the 4K code space
  localparam logic [11:0] VECTOR_LAST   = 12'h05f;
  localparam logic [11:0] BOOT_LAST     = 12'h1ff;
  localparam logic [11:0] MAIN_LAST     = 12'heff;
  localparam logic [11:0] FREE_LAST     = 12'hffb;
  localparam logic [11:0] CFG_LOW_ADDR  = 12'hffe;
  localparam logic [11:0] CFG_HIGH_ADDR = 12'hfff;
  localparam logic [3:0]  CPU_HIGH_ZERO = 4'h0;

  // Register offsets in the special register space
  localparam logic [7:0] FLASH_COMMAND_OFS = 8'h97;
  localparam logic [7:0] WRITE_GATE_OFS    = 8'hc9;
  localparam logic [7:0] CFG_LOW_OFS       = 8'hf7;

  // Command values
  localparam logic [7:0] CMD_ALL_AREA   = 8'h65;
  localparam logic [7:0] CMD_SW_RESET   = 8'h56;
  localparam logic [7:0] CMD_WRITE_GATE = 8'h47;

  // Bit positions
  localparam int unsigned ALL_AREA_BIT = 0;
  localparam int unsigned WRITE_EN_BIT = 7;
  localparam int unsigned LOCK_BIT     = 1;

  // Reset values
  localparam logic [7:0]  BYTE_ZERO = 8'h00;
  localparam logic [11:0] ADDR_ZERO = 12'h000;

  // Program time and clock
  localparam int unsigned PROG_TIME_NS  = 200000;
  localparam int unsigned CLK_PERIOD_NS = 8;
  localparam int unsigned PROG_CYCLES   = (PROG_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Controller states
  typedef enum logic [3:0] {
    ST_LOAD_LO = 4'b0001,
    ST_LOAD_HI = 4'b0010,
    ST_IDLE    = 4'b0100,
    ST_PROG    = 4'b1000
  } fsg_state_type;

endpackage

//--- fsg_area_check.sv
`timescale 1ns/100ps
module fsg_area_check (
  input  wire logic [15:0] addr,
  input  wire logic        lock,
  input  wire logic        all_area,
  output logic             code_ok,
  output logic             xd_ok
);

  // Area decode of the CPU address
  wire in_space = (addr[15:12] == fsg_pkg::CPU_HIGH_ZERO);
  wire [11:0] a = addr[11:0];
  wire in_boot  = (a <= fsg_pkg::BOOT_LAST);
  wire in_main  = (a > fsg_pkg::BOOT_LAST) && (a <= fsg_pkg::MAIN_LAST);
  wire in_free  = (a > fsg_pkg::MAIN_LAST) && (a <= fsg_pkg::FREE_LAST);
  wire in_cfg_l = (a > fsg_pkg::FREE_LAST) && (a < fsg_pkg::CFG_HIGH_ADDR);

  // Table reads blocked in a locked boot area and outside the 4K space
  assign code_ok = in_space && !(in_boot && lock);

  // Data moves per area; top configuration byte never reachable
  assign xd_ok = in_space && ((in_boot && !lock && all_area)
                           || (in_main && all_area)
                           || in_free
                           || (in_cfg_l && all_area));

endmodule

//--- fsg_prog_timer.sv
`timescale 1ns/100ps
module fsg_prog_timer #(
  parameter int unsigned CYCLES = fsg_pkg::PROG_CYCLES
) (
  input  wire logic clk,
  input  wire logic rst,
  input  wire logic start,
  output logic      done
);

  localparam int unsigned CNT_W = $clog2(CYCLES + 1);
  localparam logic [CNT_W-1:0] CNT_LOAD = CNT_W'(CYCLES);
  localparam logic [CNT_W-1:0] CNT_ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] CNT_ZERO = '0;

  // Refuse a program time that the counter cannot serve
  if (CYCLES < 1)
  begin : g_cycles_check
    $error("program time must be at least one cycle");
  end

  logic [CNT_W-1:0] cnt_reg;
  logic             done_reg;

  // Down counter, done pulses one cycle after the last cycle of the program time
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      cnt_reg  <= CNT_ZERO;
      done_reg <= 1'b0;
    end
    else
    begin
      done_reg <= (cnt_reg == CNT_ONE) && !start;
      if (start)
        cnt_reg <= CNT_LOAD;
      else if (cnt_reg != CNT_ZERO)
        cnt_reg <= cnt_reg - CNT_ONE;
    end
  end

  assign done = done_reg;

endmodule

//--- fsg_gate.sv
`timescale 1ns/100ps
// Notes on behaviour
// - One 4K flash serves fetch and data
// - Top four bytes are configuration; two load
// - Vector range at bottom is always fetchable
// - Boot area: lock blocks table reads and data moves, not fetches, else data moves gated
// - Main area: table reads free, data move reads and writes need flag
// - Free data area always readable, writable when write enable set
// - After reset nothing is writable until gate opens, then only free area
// - Config bytes gated; top byte never moved
// - Power-on copies low byte; software overrides
// - Command 65h sets area flag, others clear
// - Command register reads area flag, bit 0
// - Gate 47h sets write enable, bit 7
// - Data move write programs only when enabled
// - Bytes programmed in place, no erase
// - CPU stalls during programming; rest keeps running
// - Reads add no CPU wait time
// - Lock bit is bit 1 of top byte
// - Command 56h requests a software reset
module fsg_gate #(
  parameter int unsigned PROG_CYCLES = fsg_pkg::PROG_CYCLES
) (
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        por,
  // Special register port
  input  wire logic [7:0]  sfr_addr,
  input  wire logic        sfr_wr,
  input  wire logic        sfr_rd,
  input  wire logic [7:0]  sfr_wdata,
  output logic      [7:0]  sfr_rdata,
  output logic             sfr_hit,
  // Instruction fetch, code-table read and data move ports
  input  wire logic        fetch_rd,
  input  wire logic [11:0] fetch_addr,
  input  wire logic        code_rd,
  input  wire logic [15:0] code_addr,
  input  wire logic        xd_rd,
  input  wire logic        xd_wr,
  input  wire logic [15:0] xd_addr,
  input  wire logic [7:0]  xd_wdata,
  output logic      [7:0]  rd_data,
  output logic             rd_valid,
  output logic             cpu_stall,
  output logic             sw_reset_req,
  // Configuration values for the rest of the chip
  output logic      [7:0]  cfg_low,
  output logic      [7:0]  cfg_high,
  // Flash array port, read data follows the address combinationally
  output logic      [11:0] fl_addr,
  output logic      [7:0]  fl_wdata,
  output logic             fl_prog,
  input  wire logic [7:0]  fl_rdata
);

  // Refuse a program time that the timer cannot count
  if (PROG_CYCLES < 1)
  begin : g_prog_check
    $error("program time must be at least one cycle");
  end

  fsg_pkg::fsg_state_type state_reg;
  fsg_pkg::fsg_state_type state_next;

  logic        all_area_reg;
  logic        write_en_reg;
  logic [7:0]  cfg_low_reg;
  logic [7:0]  cfg_high_reg;
  logic [7:0]  sfr_rdata_reg;
  logic        sfr_hit_reg;
  logic [7:0]  rd_data_reg;
  logic        rd_valid_reg;
  logic        rd_pend_reg;
  logic        rd_ok_reg;
  logic        stall_reg;
  logic        sw_reset_reg;
  logic [11:0] fl_addr_reg;
  logic [11:0] fl_addr_next;
  logic [7:0]  fl_wdata_reg;
  logic        fl_prog_reg;

  wire  lock_bit = cfg_high_reg[fsg_pkg::LOCK_BIT];

  // Permission check for code-table reads
  logic code_ok;
  fsg_area_check u_code_check (
    .addr     (code_addr),
    .lock     (lock_bit),
    .all_area (all_area_reg),
    .code_ok  (code_ok),
    .xd_ok    ()
  );

  // Permission check for data moves
  logic xd_ok;
  fsg_area_check u_xd_check (
    .addr     (xd_addr),
    .lock     (lock_bit),
    .all_area (all_area_reg),
    .code_ok  (),
    .xd_ok    (xd_ok)
  );

  // Program time counter, stalls the CPU only
  logic prog_start;
  logic prog_done;
  fsg_prog_timer #(
    .CYCLES (PROG_CYCLES)
  ) u_timer (
    .clk   (clk),
    .rst   (rst),
    .start (prog_start),
    .done  (prog_done)
  );

  // Special register decode
  wire sel_cmd  = (sfr_addr == fsg_pkg::FLASH_COMMAND_OFS);
  wire sel_gate = (sfr_addr == fsg_pkg::WRITE_GATE_OFS);
  wire sel_low  = (sfr_addr == fsg_pkg::CFG_LOW_OFS);
  wire sel_any  = sel_cmd || sel_gate || sel_low;
  wire wr_cmd   = sfr_wr && sel_cmd;
  wire wr_gate  = sfr_wr && sel_gate;
  wire wr_low   = sfr_wr && sel_low;

  // Command value decode
  wire cmd_is_area  = (sfr_wdata == fsg_pkg::CMD_ALL_AREA);
  wire gate_is_open = (sfr_wdata == fsg_pkg::CMD_WRITE_GATE);
  wire cmd_is_reset = wr_cmd && (sfr_wdata == fsg_pkg::CMD_SW_RESET);

  // Read values of the three registers
  wire [7:0] cmd_view  = {7'h00, all_area_reg};
  wire [7:0] gate_view = {write_en_reg, 7'h00};
  wire [7:0] sfr_view  = sel_cmd  ? cmd_view  :
                         sel_gate ? gate_view :
                         sel_low  ? cfg_low_reg : fsg_pkg::BYTE_ZERO;

  // Request qualification in the running state
  wire idle      = (state_reg == fsg_pkg::ST_IDLE);
  wire fetch_go  = idle && fetch_rd;
  wire code_go   = idle && !fetch_rd && code_rd;
  wire xdr_go    = idle && !fetch_rd && !code_rd && xd_rd;
  wire any_rd    = fetch_go || code_go || xdr_go;
  wire rd_ok     = fetch_go || (code_go && code_ok) || (xdr_go && xd_ok);
  // A write beside a read would program the read address, so reads win
  wire xdw_take  = idle && !any_rd && xd_wr && xd_ok && write_en_reg;
  assign prog_start = xdw_take;

  // Flash address source
  always_comb
  begin
    fl_addr_next = fl_addr_reg;
    if (fetch_go)
      fl_addr_next = fetch_addr;
    else if (code_go)
      fl_addr_next = code_addr[11:0];
    else if (xdr_go)
      fl_addr_next = xd_addr[11:0];
    else if (xdw_take)
      fl_addr_next = xd_addr[11:0];
  end

  // Controller sequence: config load after power-on, then serve requests
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      fsg_pkg::ST_LOAD_LO: state_next = fsg_pkg::ST_LOAD_HI;
      fsg_pkg::ST_LOAD_HI: state_next = fsg_pkg::ST_IDLE;
      fsg_pkg::ST_IDLE:
      begin
        if (xdw_take)
          state_next = fsg_pkg::ST_PROG;
      end
      fsg_pkg::ST_PROG:
      begin
        if (prog_done)
          state_next = fsg_pkg::ST_IDLE;
      end
      default: state_next = fsg_pkg::ST_IDLE;
    endcase
  end

  // State and stall
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      state_reg <= por ? fsg_pkg::ST_LOAD_LO : fsg_pkg::ST_IDLE;
      stall_reg <= por;
    end
    else
    begin
      state_reg <= state_next;
      stall_reg <= (state_next != fsg_pkg::ST_IDLE);
    end
  end

  // Flash port: the load walks from the low to the high config byte
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      fl_addr_reg  <= por ? fsg_pkg::CFG_LOW_ADDR : fsg_pkg::ADDR_ZERO;
      fl_wdata_reg <= fsg_pkg::BYTE_ZERO;
      fl_prog_reg  <= 1'b0;
    end
    else
    begin
      if (state_reg == fsg_pkg::ST_LOAD_LO)
        fl_addr_reg <= fsg_pkg::CFG_HIGH_ADDR;
      else
        fl_addr_reg <= fl_addr_next;
      if (xdw_take)
        fl_wdata_reg <= xd_wdata;
      fl_prog_reg <= (state_next == fsg_pkg::ST_PROG);
    end
  end

  // Configuration copies; other resets keep the loaded values
  always_ff @(posedge clk)
  begin
    if (state_reg == fsg_pkg::ST_LOAD_LO)
      cfg_low_reg <= fl_rdata;
    else if (wr_low && !rst)
      cfg_low_reg <= sfr_wdata;
    if (state_reg == fsg_pkg::ST_LOAD_HI)
      cfg_high_reg <= fl_rdata;
  end

  // Access flags, cleared by every reset; 56h counts as another value
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      all_area_reg <= 1'b0;
      write_en_reg <= 1'b0;
    end
    else
    begin
      if (wr_cmd)
        all_area_reg <= cmd_is_area;
      if (wr_gate)
        write_en_reg <= gate_is_open;
    end
  end

  // Software reset request, a pulse one cycle after the command
  always_ff @(posedge clk)
  begin
    if (rst)
      sw_reset_reg <= 1'b0;
    else
      sw_reset_reg <= cmd_is_reset;
  end

  // Special register read data
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      sfr_rdata_reg <= fsg_pkg::BYTE_ZERO;
      sfr_hit_reg   <= 1'b0;
    end
    else
    begin
      sfr_rdata_reg <= sfr_rd ? sfr_view : fsg_pkg::BYTE_ZERO;
      sfr_hit_reg   <= sfr_rd && sel_any;
    end
  end

  // Read pipeline: address out, then data back, no stall
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      rd_pend_reg  <= 1'b0;
      rd_ok_reg    <= 1'b0;
      rd_valid_reg <= 1'b0;
      rd_data_reg  <= fsg_pkg::BYTE_ZERO;
    end
    else
    begin
      rd_pend_reg  <= any_rd;
      rd_ok_reg    <= rd_ok;
      rd_valid_reg <= rd_pend_reg;
      if (rd_pend_reg)
        rd_data_reg <= rd_ok_reg ? fl_rdata : fsg_pkg::BYTE_ZERO;
    end
  end

  // Outputs straight from flip-flops
  assign sfr_rdata    = sfr_rdata_reg;
  assign sfr_hit      = sfr_hit_reg;
  assign rd_data      = rd_data_reg;
  assign rd_valid     = rd_valid_reg;
  assign cpu_stall    = stall_reg;
  assign sw_reset_req = sw_reset_reg;
  assign cfg_low      = cfg_low_reg;
  assign cfg_high     = cfg_high_reg;
  assign fl_addr      = fl_addr_reg;
  assign fl_wdata     = fl_wdata_reg;
  assign fl_prog      = fl_prog_reg;

endmodule

//--- fsg_monitor.sv
`timescale 1ns/100ps
module fsg_monitor #(
  parameter int unsigned PROG_CYCLES = fsg_pkg::PROG_CYCLES
) (
  input wire logic        clk,
  input wire logic        rst,
  input wire logic [7:0]  sfr_addr,
  input wire logic        sfr_wr,
  input wire logic        sfr_rd,
  input wire logic [7:0]  sfr_wdata,
  input wire logic [7:0]  sfr_rdata,
  input wire logic        sfr_hit,
  input wire logic        fetch_rd,
  input wire logic        code_rd,
  input wire logic        xd_rd,
  input wire logic        xd_wr,
  input wire logic [15:0] xd_addr,
  input wire logic [7:0]  xd_wdata,
  input wire logic        rd_valid,
  input wire logic        cpu_stall,
  input wire logic        sw_reset_req,
  input wire logic [11:0] fl_addr,
  input wire logic [7:0]  fl_wdata,
  input wire logic        fl_prog
);
  logic [15:0] hi_cnt_reg;
  wire         rd_req = fetch_rd | code_rd | xd_rd;
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // Length of the current program pulse
  always_ff @(posedge clk)
    hi_cnt_reg <= fl_prog ? hi_cnt_reg + 16'h0001 : 16'h0000;
  // Read path, register port and program pulse
  read_lat_a: assert property (rd_req && !cpu_stall |-> ##2 rd_valid)
    else $error("read answer late");
  read_src_a: assert property (rd_valid |-> $past(rd_req, 2))
    else $error("answer without read");
  cmd_read_a: assert property (
    sfr_rd && sfr_addr == 8'h97 |=> sfr_hit && sfr_rdata[7:1] == 7'h00)
    else $error("command read bad");
  area_set_a: assert property (
    sfr_wr && sfr_addr == 8'h97 && sfr_wdata == 8'h65 ##1 !sfr_wr ##1
    sfr_rd && !sfr_wr && sfr_addr == 8'h97 |=> sfr_rdata == 8'h01)
    else $error("area flag not set");
  gate_set_a: assert property (
    sfr_wr && sfr_addr == 8'hc9 && sfr_wdata == 8'h47 ##1 !sfr_wr ##1
    sfr_rd && !sfr_wr && sfr_addr == 8'hc9 |=> sfr_rdata == 8'h80)
    else $error("write gate not set");
  sw_reset_a: assert property (
    sfr_wr && sfr_addr == 8'h97 && sfr_wdata == 8'h56 |=> sw_reset_req)
    else $error("no reset request");
  prog_len_a: assert property ($fell(fl_prog) |-> hi_cnt_reg == PROG_CYCLES + 1)
    else $error("program length wrong");
  stall_prog_a: assert property (fl_prog |-> cpu_stall)
    else $error("no stall in program");
  prog_cause_a: assert property (
    $rose(fl_prog) |-> $past(xd_wr) && {4'h0, fl_addr} == $past(xd_addr)
    && fl_wdata == $past(xd_wdata))
    else $error("program target wrong");
  top_byte_a: assert property (xd_wr && !cpu_stall && xd_addr == 16'h0fff |=> !fl_prog)
    else $error("top byte programmed");
  cover property ($rose(fl_prog));
  cover property (sw_reset_req);
  cover property (sfr_hit);
endmodule
bind fsg_gate fsg_monitor #(.PROG_CYCLES(PROG_CYCLES)) u_mon (.clk, .rst, .sfr_addr, .sfr_wr,
  .sfr_rd, .sfr_wdata, .sfr_rdata, .sfr_hit, .fetch_rd, .code_rd, .xd_rd, .xd_wr, .xd_addr,
  .xd_wdata, .rd_valid, .cpu_stall, .sw_reset_req, .fl_addr, .fl_wdata, .fl_prog);

//--- fsg_flash_model.sv
`timescale 1ns/100ps
module fsg_flash_model (
  input wire logic        clk,
  input wire logic [11:0] fl_addr,
  input wire logic [7:0]  fl_wdata,
  input wire logic        fl_prog,
  output logic     [7:0]  fl_rdata
);
  logic [7:0] mem [4096];
  logic       prog_q;
  // Each byte starts as its low address bits
  initial
  begin
    for (int i = 0; i < 4096; i++)
      mem[i] = 8'(i);
  end
  // One array serves fetch and data, no wait
  assign fl_rdata = mem[fl_addr];
  // Single byte overwritten in place, no erase
  always @(posedge clk)
  begin
    prog_q <= fl_prog;
    if (fl_prog && !prog_q)
      mem[fl_addr] <= fl_wdata;
  end
endmodule

//--- fsg_gate_tb.sv
`timescale 1ns/100ps
module fsg_gate_tb;
  logic        clk, rst, por, sfr_wr, sfr_rd, fetch_rd, code_rd, xd_rd, xd_wr;
  logic        sfr_hit, rd_valid, cpu_stall, sw_reset_req, fl_prog;
  logic [7:0]  sfr_addr, sfr_wdata, sfr_rdata, xd_wdata, rd_data, cfg_low, cfg_high;
  logic [7:0]  fl_wdata, fl_rdata;
  logic [11:0] fetch_addr, fl_addr;
  logic [15:0] code_addr, xd_addr;
  int          n_errors, n_tests;
  localparam logic [12:0] TAB [9] = '{13'h01a7, 13'h11a7, 13'h02a5, 13'h1eff, 13'h0f3c,
    13'h0ffb, 13'h0ffc, 13'h1ffe, 13'h1fff};
  localparam logic [8:0]  XOK = 9'b010111010;
  fsg_gate #(.PROG_CYCLES(8)) dut (.clk, .rst, .por, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata,
    .sfr_rdata, .sfr_hit, .fetch_rd, .fetch_addr, .code_rd, .code_addr, .xd_rd, .xd_wr,
    .xd_addr, .xd_wdata, .rd_data, .rd_valid, .cpu_stall, .sw_reset_req, .cfg_low,
    .cfg_high, .fl_addr, .fl_wdata, .fl_prog, .fl_rdata);
  fsg_flash_model u_fl (.clk, .fl_addr, .fl_wdata, .fl_prog, .fl_rdata);
  // 125 MHz clock
  initial
  begin
    clk = 0;
    forever #4 clk = ~clk;
  end
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("FAIL %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic sfr_w(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    sfr_wr <= 1;
    sfr_addr <= a;
    sfr_wdata <= d;
    @(posedge clk);
    sfr_wr <= 0;
  endtask
  task automatic sfr_r(input logic [7:0] a, input logic [7:0] e, input logic h);
    @(posedge clk);
    sfr_rd <= 1;
    sfr_addr <= a;
    @(posedge clk);
    sfr_rd <= 0;
    @(negedge clk);
    chk(sfr_rdata, e);
    chk(sfr_hit, h);
  endtask
  // Kind 0 fetch, 1 code-table read, 2 data move read
  task automatic rd(input int k, input logic [11:0] a, input logic [7:0] e);
    @(posedge clk);
    {fetch_rd, code_rd, xd_rd} <= 3'b100 >> k;
    fetch_addr <= a;
    code_addr <= {4'h0, a};
    xd_addr <= {4'h0, a};
    @(posedge clk);
    {fetch_rd, code_rd, xd_rd} <= 3'b000;
    @(posedge clk);
    @(negedge clk);
    chk(rd_valid, 1'b1);
    chk(rd_data, e);
  endtask
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic e);
    @(posedge clk);
    xd_wr <= 1;
    xd_addr <= {4'h0, a};
    xd_wdata <= d;
    @(posedge clk);
    xd_wr <= 0;
    @(negedge clk);
    chk(fl_prog, e);
    chk(cpu_stall, e);
    for (int i = 0; i < 40 && cpu_stall !== 1'b0; i++)
      @(negedge clk);
    chk(cpu_stall, 1'b0);
  endtask
  // Power-on reset with a chosen top configuration byte
  task automatic boot(input logic [7:0] hi);
    @(posedge clk);
    rst <= 1;
    por <= 1;
    repeat (20) @(posedge clk);
    u_fl.mem[12'hfff] = hi;
    rst <= 0;
    por <= 0;
    for (int i = 0; i < 10 && cpu_stall !== 1'b0; i++)
      @(negedge clk);
    chk(cfg_low, 8'hfe);
    chk(cfg_high, hi);
    sfr_r(8'h97, 8'h00, 1'b1);
    sfr_r(8'hc9, 8'h00, 1'b1);
  endtask
  task automatic t_regs;
    sfr_w(8'h97, 8'h65);
    sfr_r(8'h97, 8'h01, 1'b1);
    sfr_w(8'h97, 8'h64);
    sfr_r(8'h97, 8'h00, 1'b1);
    sfr_w(8'hc9, 8'h47);
    sfr_r(8'hc9, 8'h80, 1'b1);
    sfr_w(8'hc9, 8'h48);
    sfr_r(8'hc9, 8'h00, 1'b1);
    sfr_w(8'hf7, 8'h3c);
    sfr_r(8'hf7, 8'h3c, 1'b1);
    sfr_r(8'h80, 8'h00, 1'b0);
    sfr_w(8'h97, 8'h56);
    @(negedge clk);
    chk(sw_reset_req, 1'b1);
    $display("register test done");
  endtask
  task automatic t_perm;
    logic [11:0] a;
    logic [7:0]  v;
    for (int i = 0; i < 9; i++)
    begin
      a = TAB[i][11:0];
      v = (a == 12'hfff) ? 8'h0c : a[7:0];
      sfr_w(8'h97, TAB[i][12] ? 8'h65 : 8'h00);
      rd(1, a, v);
      rd(2, a, XOK[i] ? v : 8'h00);
    end
    $display("permission test done");
  endtask
  task automatic t_write;
    sfr_w(8'h97, 8'h00);
    sfr_w(8'hc9, 8'h47);
    wr(12'hf00, 8'h5a, 1'b1);
    wr(12'h2a5, 8'h11, 1'b0);
    sfr_w(8'h97, 8'h65);
    wr(12'hfff, 8'h22, 1'b0);
    wr(12'hffc, 8'h33, 1'b1);
    wr(12'h1a7, 8'h44, 1'b1);
    sfr_w(8'hc9, 8'h00);
    wr(12'hf01, 8'h55, 1'b0);
    rd(2, 12'hf00, 8'h5a);
    rd(1, 12'h1a7, 8'h44);
    rd(1, 12'hf01, 8'h01);
    rd(1, 12'h2a5, 8'ha5);
    $display("write test done");
  endtask
  task automatic t_lock;
    boot(8'h02);
    rd(0, 12'h010, 8'h10);
    rd(1, 12'h1a7, 8'h00);
    rd(1, 12'h2a5, 8'ha5);
    sfr_w(8'h97, 8'h65);
    sfr_w(8'hc9, 8'h47);
    rd(2, 12'h1a7, 8'h00);
    wr(12'h1a7, 8'h66, 1'b0);
    $display("lock test done");
  endtask
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  // Main sequence
  initial
  begin
    {rst, por, sfr_wr, sfr_rd, fetch_rd, code_rd, xd_rd, xd_wr} = 8'h00;
    {sfr_addr, sfr_wdata, xd_wdata} = 24'h000000;
    {fetch_addr, code_addr, xd_addr} = 44'h00000000000;
    boot(8'h0c);
    t_regs;
    t_perm;
    t_write;
    t_lock;
    complete_run;
  end
  // Hang guard
  initial
  begin
    #200000;
    n_errors++;
    complete_run;
  end
endmodule
